// file: src/pdma_regs.svh
// Purpose: Offsets, field positions, reset values and sizes of the peripheral DMA block
// Assumes: Byte addresses on a 12-bit register port, one 32-bit word per register
// Notes: Definitions only
`ifndef PDMA_REGS_SVH
`define PDMA_REGS_SVH
// Structure sizes
`define PDMA_NCH 4
`define PDMA_NMON 2
`define PDMA_CW 16
`define PDMA_CMAX 16'hffff
// Per-channel offsets inside a 0x40 window
`define PDMA_OFS_MEM_PTR 6'h00
`define PDMA_OFS_SELECTOR 6'h04
`define PDMA_OFS_COUNTER 6'h08
`define PDMA_OFS_PTR_RELOAD 6'h0c
`define PDMA_OFS_CNT_RELOAD 6'h10
`define PDMA_OFS_CONTROL 6'h14
`define PDMA_OFS_MODE 6'h18
`define PDMA_OFS_STATE 6'h1c
`define PDMA_OFS_IRQ_SET 6'h20
`define PDMA_OFS_IRQ_CLR 6'h24
`define PDMA_OFS_IRQ_MASK 6'h28
`define PDMA_OFS_IRQ_FLAGS 6'h2c
// Monitor, control and revision offsets
`define PDMA_OFS_PERF 12'h800
`define PDMA_OFS_MON 12'h804
`define PDMA_MON_STRIDE 12'h018
`define PDMA_MON_RDAT 12'h000
`define PDMA_MON_RSTL 12'h004
`define PDMA_MON_RLAT 12'h008
`define PDMA_MON_WDAT 12'h00c
`define PDMA_MON_WSTL 12'h010
`define PDMA_MON_WLAT 12'h014
`define PDMA_OFS_REV 12'h834
// Control, status and flag bits
`define PDMA_CR_ON 0
`define PDMA_CR_OFF 1
`define PDMA_ERROR_CLEAR_BIT 8
`define PDMA_SR_EN 0
`define PDMA_IRQ_RCZ 0
`define PDMA_IRQ_TRC 1
`define PDMA_IRQ_TERR 2
// Selector fields: direction and handshake interface
`define PDMA_PID_DIR 0
`define PDMA_PID_HS_LO 1
`define PDMA_PID_HS_HI 2
// Monitor control fields
`define PDMA_PC_EN 0
`define PDMA_PC_RES 4
`define PDMA_PC_OVF 8
`define PDMA_PC_SEL 16
`define PDMA_PC_SEL_STEP 8
// Item sizes
`define PDMA_SZ_BYTE 2'h0
`define PDMA_SZ_HALF 2'h1
`define PDMA_SZ_WORD 2'h2
// Reset value and revision code (revision value is arbitrary)
`define PDMA_RST_ZERO 32'h00000000
`define PDMA_REV_ID 32'h00000001
`endif

// file: src/pdma_pkg.sv
// Purpose: Types shared by the peripheral DMA block
// Assumes: pdma_regs.svh gives the sizes
// Notes: All carriers are packed structs
`include "pdma_regs.svh"
package pdma_pkg;
   typedef enum logic [2:0] {
      PDMA_S_IDLE = 3'b001,
      PDMA_S_PER = 3'b010,
      PDMA_S_MEM = 3'b100
   } pdma_fsm_t;
   typedef struct packed {
      logic wr;
      logic rd;
      logic [11:0] addr;
      logic [31:0] wdata;
   } pdma_regreq_t;
   typedef struct packed {
      logic req;
      logic write;
      logic [1:0] size;
      logic [31:0] addr;
      logic [31:0] wdata;
   } pdma_memreq_t;
   typedef struct packed {
      logic ready;
      logic error;
      logic [31:0] rdata;
   } pdma_memrsp_t;
   typedef struct packed {
      logic rd;
      logic wr;
      logic [7:0] addr;
      logic [31:0] wdata;
   } pdma_perreq_t;
   typedef struct packed {
      logic [31:0] memory_pointer;
      logic [31:0] pointer_reload;
      logic [15:0] transfer_counter;
      logic [15:0] counter_reload;
      logic [7:0] peripheral_identity;
      logic [1:0] size;
      logic en;
      logic err;
      logic [2:0] irq_mask_view;
   } pdma_chan_t;
   typedef struct packed {
      logic en;
      logic ovf;
      logic [1:0] sel;
      logic [15:0] rdat;
      logic [15:0] rstl;
      logic [15:0] rlat;
      logic [15:0] wdat;
      logic [15:0] wstl;
      logic [15:0] wlat;
      logic [15:0] cur;
   } pdma_mon_t;
   typedef struct packed {
      pdma_chan_t [`PDMA_NCH-1:0] ch;
      pdma_mon_t [`PDMA_NMON-1:0] mon;
      pdma_fsm_t fsm;
      logic [1:0] cur;
      logic wr;
      logic m2p;
      logic [1:0] size;
      logic [31:0] addr;
      logic [31:0] data;
      logic [7:0] peripheral_identity;
      logic [31:0] rdata;
   } pdma_state_t;
   // Zero bits above the item size
   function automatic logic [31:0] pdma_fit(input logic [1:0] sz, input logic [31:0] d);
      if (sz == `PDMA_SZ_BYTE)
         return {24'h000000, d[7:0]};
      else if (sz == `PDMA_SZ_HALF)
         return {16'h0000, d[15:0]};
      else
         return d;
   endfunction : pdma_fit
   // Pointer advance per item
   function automatic logic [31:0] pdma_step(input logic [1:0] sz);
      if (sz == `PDMA_SZ_BYTE)
         return 32'h00000001;
      else if (sz == `PDMA_SZ_HALF)
         return 32'h00000002;
      else
         return 32'h00000004;
   endfunction : pdma_step
endpackage : pdma_pkg

// file: src/pdma_channels.sv
// Purpose: Multi-channel peripheral DMA engine with reload, error stop and two monitors
// Assumes: Peripherals and memory bus on mclk; one item moved at a time
// Notes: Peripheral read data is taken in the same cycle as the read strobe
// Behaviour
// - Empty counter with reload pending loads both
// - Reload clears both reload registers
// - Reload write on empty counter loads immediately
// - Selector picks handshake, direction, holding address
// - Per-channel byte, halfword or word size
// - Memory access carries programmed size
// - Peripheral data zeroed above item size
// - On/off bits enable channel, state readable
// - Enabled channel served while items remain
// - Set/clear registers drive readable mask
// - Flag reload-zero and transfer-finished conditions
// - Failed memory access raises error source
// - Lowest-numbered requesting channel wins
// - Error sets flag, stops that channel
// - Error-clear write resumes stopped channel
// - Masked error raises interrupt request
// - Monitor counts selected channel while enabled
// - Count data, stall, latency per direction
// - Counter overflow resets or freezes monitor
// - Monitor reset bit clears its counters
// - Latency saturates, cleared only by reset
// - Pointer advances by item size
// - Counter decrements per finished item
// - Request acknowledged when transfer starts
`timescale 1ns/1ns
`include "pdma_regs.svh"
module pdma_channels
   import pdma_pkg::*;
(
   input wire logic mclk,
   input wire logic reset,
   input wire logic ce,
   input wire pdma_regreq_t reg_req,
   output logic [31:0] reg_rdata,
   output pdma_memreq_t mem_req,
   input wire pdma_memrsp_t mem_rsp,
   output pdma_perreq_t per_req,
   input wire logic [31:0] per_rdata,
   input wire logic [3:0] hs_req,
   output logic [3:0] hs_ack,
   output logic [`PDMA_NCH-1:0] irq
);
   localparam int NCH = `PDMA_NCH;
   localparam int NMON = `PDMA_NMON;

   pdma_state_t st;
   pdma_state_t n;
   logic [NCH-1:0] elig;
   logic [NCH-1:0] grant;
   logic [NCH-1:0] tcr_wr;
   logic [NCH-1:0][2:0] isr_v;
   logic [NMON-1:0] mres;
   logic [1:0] sel;
   logic [1:0] wc;
   logic done;
   logic err_set;
   logic [31:0] rd_val;
   logic [11:0] mb;
   logic obs;
   logic wrap;
   logic frz;
   logic [15:0] curn;

   ////////////////////////////////////////////////////////////////////////////
   // Next-state logic
   always_comb
   begin
      n = st;
      elig = '0;
      grant = '0;
      tcr_wr = '0;
      hs_ack = 4'h0;
      mres = '0;
      sel = 2'h0;
      wc = reg_req.addr[7:6];
      done = 1'b0;
      err_set = 1'b0;
      rd_val = `PDMA_RST_ZERO;
      mb = 12'h000;
      obs = 1'b0;
      wrap = 1'b0;
      frz = 1'b0;
      curn = 16'h0000;
      for (int c = 0; c < NCH; c++)
      begin
         isr_v[c][`PDMA_IRQ_RCZ] = (st.ch[c].counter_reload == 16'h0000);
         isr_v[c][`PDMA_IRQ_TRC] = (st.ch[c].transfer_counter == 16'h0000) && (st.ch[c].counter_reload == 16'h0000);
         isr_v[c][`PDMA_IRQ_TERR] = st.ch[c].err;
      end
      for (int c = 0; c < NCH; c++)
      begin
         elig[c] = ce && st.ch[c].en && !st.ch[c].err && (st.ch[c].transfer_counter != 16'h0000)
                   && hs_req[st.ch[c].peripheral_identity[`PDMA_PID_HS_HI:`PDMA_PID_HS_LO]];
      end
      for (int c = NCH - 1; c >= 0; c--)
      begin
         if (elig[c])
            sel = 2'(c);
      end
      // Transfer sequencer
      case (st.fsm)
         PDMA_S_IDLE:
         begin
            if (|elig)
            begin
               grant[sel] = 1'b1;
               hs_ack[st.ch[sel].peripheral_identity[`PDMA_PID_HS_HI:`PDMA_PID_HS_LO]] = 1'b1;
               n.cur = sel;
               n.m2p = st.ch[sel].peripheral_identity[`PDMA_PID_DIR];
               n.wr = !st.ch[sel].peripheral_identity[`PDMA_PID_DIR];
               n.peripheral_identity = st.ch[sel].peripheral_identity;
               n.size = st.ch[sel].size;
               n.addr = st.ch[sel].memory_pointer;
               n.fsm = st.ch[sel].peripheral_identity[`PDMA_PID_DIR] ? PDMA_S_MEM : PDMA_S_PER;
            end
         end
         PDMA_S_PER:
         begin
            if (st.m2p)
            begin
               done = 1'b1;
               n.fsm = PDMA_S_IDLE;
            end
            else
            begin
               n.data = pdma_fit(st.size, per_rdata);
               n.fsm = PDMA_S_MEM;
            end
         end
         PDMA_S_MEM:
         begin
            if (mem_rsp.ready)
            begin
               if (mem_rsp.error)
               begin
                  err_set = 1'b1;
                  n.fsm = PDMA_S_IDLE;
               end
               else if (!st.wr)
               begin
                  n.data = pdma_fit(st.size, mem_rsp.rdata);
                  n.fsm = PDMA_S_PER;
               end
               else
               begin
                  done = 1'b1;
                  n.fsm = PDMA_S_IDLE;
               end
            end
         end
         default:
         begin
            n.fsm = PDMA_S_IDLE;
         end
      endcase
      if (done)
      begin
         n.ch[st.cur].memory_pointer = st.ch[st.cur].memory_pointer + pdma_step(st.size);
         n.ch[st.cur].transfer_counter = st.ch[st.cur].transfer_counter - 16'h0001;
      end
      // Register writes, software wins over the engine except on the error flag, set after them
      if (reg_req.wr && reg_req.addr[11:8] == 4'h0)
      begin
         case (reg_req.addr[5:0])
            `PDMA_OFS_MEM_PTR: n.ch[wc].memory_pointer = reg_req.wdata;
            `PDMA_OFS_SELECTOR: n.ch[wc].peripheral_identity = reg_req.wdata[7:0];
            `PDMA_OFS_COUNTER:
            begin
               n.ch[wc].transfer_counter = reg_req.wdata[15:0];
               tcr_wr[wc] = 1'b1;
            end
            `PDMA_OFS_PTR_RELOAD: n.ch[wc].pointer_reload = reg_req.wdata;
            `PDMA_OFS_CNT_RELOAD: n.ch[wc].counter_reload = reg_req.wdata[15:0];
            `PDMA_OFS_CONTROL:
            begin
               if (reg_req.wdata[`PDMA_CR_ON])
                  n.ch[wc].en = 1'b1;
               if (reg_req.wdata[`PDMA_CR_OFF])
                  n.ch[wc].en = 1'b0;
               if (reg_req.wdata[`PDMA_ERROR_CLEAR_BIT])
                  n.ch[wc].err = 1'b0;
            end
            `PDMA_OFS_MODE: n.ch[wc].size = reg_req.wdata[1:0];
            `PDMA_OFS_IRQ_SET: n.ch[wc].irq_mask_view = st.ch[wc].irq_mask_view | reg_req.wdata[2:0];
            `PDMA_OFS_IRQ_CLR: n.ch[wc].irq_mask_view = st.ch[wc].irq_mask_view & ~reg_req.wdata[2:0];
            default: n.ch[wc].irq_mask_view = n.ch[wc].irq_mask_view;
         endcase
      end
      if (reg_req.wr && reg_req.addr == `PDMA_OFS_PERF)
      begin
         for (int m = 0; m < NMON; m++)
         begin
            n.mon[m].en = reg_req.wdata[`PDMA_PC_EN + m];
            n.mon[m].ovf = reg_req.wdata[`PDMA_PC_OVF + m];
            n.mon[m].sel = reg_req.wdata[`PDMA_PC_SEL + m * `PDMA_PC_SEL_STEP +: 2];
            mres[m] = reg_req.wdata[`PDMA_PC_RES + m];
         end
      end
      for (int c = 0; c < NCH; c++)
      begin
         if (n.ch[c].transfer_counter == 16'h0000 && n.ch[c].counter_reload != 16'h0000)
         begin
            n.ch[c].transfer_counter = n.ch[c].counter_reload;
            n.ch[c].memory_pointer = n.ch[c].pointer_reload;
            n.ch[c].counter_reload = 16'h0000;
            n.ch[c].pointer_reload = 32'h00000000;
         end
      end
      if (err_set)
         n.ch[st.cur].err = 1'b1;
      // Performance monitors
      for (int m = 0; m < NMON; m++)
      begin
         obs = (st.fsm == PDMA_S_MEM) && (st.cur == st.mon[m].sel);
         frz = st.mon[m].ovf && (st.mon[m].rdat == `PDMA_CMAX || st.mon[m].rstl == `PDMA_CMAX
               || st.mon[m].wdat == `PDMA_CMAX || st.mon[m].wstl == `PDMA_CMAX);
         wrap = 1'b0;
         curn = (st.mon[m].cur == `PDMA_CMAX) ? `PDMA_CMAX : st.mon[m].cur + 16'h0001;
         if (mres[m])
         begin
            n.mon[m].rdat = 16'h0000;
            n.mon[m].rstl = 16'h0000;
            n.mon[m].rlat = 16'h0000;
            n.mon[m].wdat = 16'h0000;
            n.mon[m].wstl = 16'h0000;
            n.mon[m].wlat = 16'h0000;
            n.mon[m].cur = 16'h0000;
         end
         else if (st.mon[m].en && !frz && obs)
         begin
            if (mem_rsp.ready)
            begin
               n.mon[m].cur = 16'h0000;
               if (st.wr)
               begin
                  wrap = (st.mon[m].wdat == `PDMA_CMAX);
                  n.mon[m].wdat = st.mon[m].wdat + 16'h0001;
               end
               else
               begin
                  wrap = (st.mon[m].rdat == `PDMA_CMAX);
                  n.mon[m].rdat = st.mon[m].rdat + 16'h0001;
               end
            end
            else
            begin
               n.mon[m].cur = curn;
               if (st.wr)
               begin
                  wrap = (st.mon[m].wstl == `PDMA_CMAX);
                  n.mon[m].wstl = st.mon[m].wstl + 16'h0001;
                  if (curn > st.mon[m].wlat)
                     n.mon[m].wlat = curn;
               end
               else
               begin
                  wrap = (st.mon[m].rstl == `PDMA_CMAX);
                  n.mon[m].rstl = st.mon[m].rstl + 16'h0001;
                  if (curn > st.mon[m].rlat)
                     n.mon[m].rlat = curn;
               end
            end
            if (wrap)
            begin
               n.mon[m].rdat = 16'h0000;
               n.mon[m].rstl = 16'h0000;
               n.mon[m].wdat = 16'h0000;
               n.mon[m].wstl = 16'h0000;
            end
         end
      end
      // Register read mux
      if (reg_req.addr[11:8] == 4'h0)
      begin
         case (reg_req.addr[5:0])
            `PDMA_OFS_MEM_PTR: rd_val = st.ch[wc].memory_pointer;
            `PDMA_OFS_SELECTOR: rd_val = {24'h000000, st.ch[wc].peripheral_identity};
            `PDMA_OFS_COUNTER: rd_val = {16'h0000, st.ch[wc].transfer_counter};
            `PDMA_OFS_PTR_RELOAD: rd_val = st.ch[wc].pointer_reload;
            `PDMA_OFS_CNT_RELOAD: rd_val = {16'h0000, st.ch[wc].counter_reload};
            `PDMA_OFS_MODE: rd_val = {30'h00000000, st.ch[wc].size};
            `PDMA_OFS_STATE: rd_val = {31'h00000000, st.ch[wc].en};
            `PDMA_OFS_IRQ_MASK: rd_val = {29'h00000000, st.ch[wc].irq_mask_view};
            `PDMA_OFS_IRQ_FLAGS: rd_val = {29'h00000000, isr_v[wc]};
            default: rd_val = `PDMA_RST_ZERO;
         endcase
      end
      else if (reg_req.addr == `PDMA_OFS_REV)
         rd_val = `PDMA_REV_ID;
      else if (reg_req.addr == `PDMA_OFS_PERF)
      begin
         for (int m = 0; m < NMON; m++)
         begin
            rd_val[`PDMA_PC_EN + m] = st.mon[m].en;
            rd_val[`PDMA_PC_OVF + m] = st.mon[m].ovf;
            rd_val[`PDMA_PC_SEL + m * `PDMA_PC_SEL_STEP +: 2] = st.mon[m].sel;
         end
      end
      else
      begin
         for (int m = 0; m < NMON; m++)
         begin
            mb = 12'(`PDMA_OFS_MON + m * `PDMA_MON_STRIDE);
            if (reg_req.addr == mb + `PDMA_MON_RDAT)
               rd_val = {16'h0000, st.mon[m].rdat};
            if (reg_req.addr == mb + `PDMA_MON_RSTL)
               rd_val = {16'h0000, st.mon[m].rstl};
            if (reg_req.addr == mb + `PDMA_MON_RLAT)
               rd_val = {16'h0000, st.mon[m].rlat};
            if (reg_req.addr == mb + `PDMA_MON_WDAT)
               rd_val = {16'h0000, st.mon[m].wdat};
            if (reg_req.addr == mb + `PDMA_MON_WSTL)
               rd_val = {16'h0000, st.mon[m].wstl};
            if (reg_req.addr == mb + `PDMA_MON_WLAT)
               rd_val = {16'h0000, st.mon[m].wlat};
         end
      end
      if (reg_req.rd)
         n.rdata = rd_val;
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register, frozen while ce is low
   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         st <= '0;
         st.fsm <= PDMA_S_IDLE;
      end
      else if (ce)
         st <= n;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs
   assign reg_rdata = st.rdata;
   assign mem_req.req = (st.fsm == PDMA_S_MEM);
   assign mem_req.write = st.wr;
   assign mem_req.size = st.size;
   assign mem_req.addr = st.addr;
   assign mem_req.wdata = st.data;
   assign per_req.rd = (st.fsm == PDMA_S_PER) && !st.m2p;
   assign per_req.wr = (st.fsm == PDMA_S_PER) && st.m2p;
   assign per_req.addr = st.peripheral_identity;
   assign per_req.wdata = st.data;
   always_comb
   begin
      for (int c = 0; c < NCH; c++)
         irq[c] = |(isr_v[c] & st.ch[c].irq_mask_view);
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks per channel
   for (genvar c = 0; c < NCH; c++)
   begin : g_chk
      localparam logic [NCH-1:0] LOWER = NCH'((1 << c) - 1);
      AST_NO_STALE_RELOAD: assert property (@(posedge mclk) disable iff (reset)
         !(st.ch[c].transfer_counter == 16'h0000 && st.ch[c].counter_reload != 16'h0000))
         else $error("reload pending on empty counter");
      AST_RELOAD_CLEARS: assert property (@(posedge mclk) disable iff (reset)
         ($past(st.ch[c].transfer_counter) == 16'h0000 && st.ch[c].transfer_counter != 16'h0000 && !$past(tcr_wr[c]))
         |-> (st.ch[c].counter_reload == 16'h0000 && st.ch[c].pointer_reload == 32'h00000000))
         else $error("reload registers not cleared");
      AST_PRIO: assert property (@(posedge mclk) disable iff (reset)
         grant[c] |-> ((elig & LOWER) == '0))
         else $error("lower channel passed over");
      AST_NO_GRANT_STOPPED: assert property (@(posedge mclk) disable iff (reset)
         grant[c] |-> (st.ch[c].en && !st.ch[c].err && st.ch[c].transfer_counter != 16'h0000))
         else $error("stopped channel granted");
      AST_ERR_IRQ: assert property (@(posedge mclk) disable iff (reset)
         (st.ch[c].err && st.ch[c].irq_mask_view[`PDMA_IRQ_TERR]) |-> irq[c])
         else $error("masked error gave no interrupt");
   end

   ////////////////////////////////////////////////////////////////////////////
   // Engine and monitor checks
   AST_ERR_STOPS: assert property (@(posedge mclk) disable iff (reset)
      (ce && st.fsm == PDMA_S_MEM && mem_rsp.ready && mem_rsp.error)
      |=> (st.ch[$past(st.cur)].err && st.fsm == PDMA_S_IDLE))
      else $error("error did not stop channel");
   AST_PTR_STEP: assert property (@(posedge mclk) disable iff (reset)
      (ce && done && !reg_req.wr && st.ch[st.cur].transfer_counter > 16'h0001)
      |=> (st.ch[$past(st.cur)].memory_pointer == $past(st.ch[st.cur].memory_pointer) + pdma_step($past(st.size))))
      else $error("pointer step wrong");
   AST_TCR_DEC: assert property (@(posedge mclk) disable iff (reset)
      (ce && done && !reg_req.wr && st.ch[st.cur].transfer_counter > 16'h0001)
      |=> (st.ch[$past(st.cur)].transfer_counter == $past(st.ch[st.cur].transfer_counter) - 16'h0001))
      else $error("counter not decremented");
   AST_SIZE_MASK: assert property (@(posedge mclk) disable iff (reset)
      (per_req.wr && st.size == `PDMA_SZ_BYTE) |-> (per_req.wdata[31:8] == 24'h000000))
      else $error("byte data not trimmed");
   AST_ACK_START: assert property (@(posedge mclk) disable iff (reset)
      (|hs_ack) |=> (st.fsm != PDMA_S_IDLE) ##1 (st.fsm != PDMA_S_IDLE || st.ch[st.cur].err))
      else $error("ack without transfer");
   AST_LAT_HOLD: assert property (@(posedge mclk) disable iff (reset)
      (!$past(mres[0])) |-> (st.mon[0].rlat >= $past(st.mon[0].rlat)))
      else $error("latency dropped without reset");
   AST_MON_IDLE: assert property (@(posedge mclk) disable iff (reset)
      (!st.mon[0].en && !mres[0]) |=> $stable(st.mon[0].rdat))
      else $error("disabled monitor counted");
   AST_MON_RESET: assert property (@(posedge mclk) disable iff (reset)
      (ce && mres[1]) |=> (st.mon[1].wdat == 16'h0000 && st.mon[1].wlat == 16'h0000))
      else $error("monitor reset ignored");
endmodule : pdma_channels

// file: sim/pdma_far_model.sv
// Purpose: Memory and peripheral stand-in for the DMA block
// Assumes: One memory access at a time, two wait cycles each
// Notes: Data outside a valid cycle changes every cycle
`timescale 1ns/1ns
module pdma_far_model
   import pdma_pkg::*;
(
   input wire logic mclk,
   input wire pdma_memreq_t mem_req,
   input wire pdma_perreq_t per_req,
   output pdma_memrsp_t mem_rsp,
   output logic [31:0] per_rdata
);
   logic [31:0] tick = 32'h00000000;
   int wait_n = 0;
   // Wait count of a held request, junk pattern
   always_ff @(posedge mclk)
   begin
      tick <= tick + 32'h9e3779b9;
      wait_n <= (mem_req.req && !mem_rsp.ready) ? wait_n + 1 : 0;
   end
   // peripheral supplies data
   // Slow answer, one address fails
   always_comb
   begin
      mem_rsp.ready = mem_req.req && (wait_n >= 2);
      mem_rsp.error = mem_rsp.ready && (mem_req.addr == 32'h00000f00);
      mem_rsp.rdata = mem_rsp.ready ? ~mem_req.addr : tick;
      per_rdata = per_req.rd ? 32'hcafef00d : ~tick;
   end
endmodule : pdma_far_model

// file: sim/tb.sv
// Purpose: Self-checking bench of the DMA block
// Assumes: Register bus strobes one cycle each
// Notes: Channels 0 and 1 exercised
`timescale 1ns/1ns
module tb
   import pdma_pkg::*;
();
   logic mclk = 1'b0;
   logic reset = 1'b1;
   pdma_regreq_t reg_req = '0;
   logic [31:0] reg_rdata;
   pdma_memreq_t mem_req;
   pdma_memrsp_t mem_rsp;
   pdma_perreq_t per_req;
   logic [31:0] per_rdata;
   logic [3:0] hs_req = 4'h0;
   logic [3:0] hs_ack;
   logic [3:0] irq;
   int bad_count = 0;
   int checks_done = 0;
   logic [31:0] v;
   // 250 MHz clock
   always #2 mclk = ~mclk;
   pdma_channels i_pdma_channels (.mclk(mclk), .reset(reset), .ce(1'b1),
      .reg_req(reg_req), .reg_rdata(reg_rdata), .mem_req(mem_req), .mem_rsp(mem_rsp),
      .per_req(per_req), .per_rdata(per_rdata), .hs_req(hs_req), .hs_ack(hs_ack), .irq(irq));
   pdma_far_model i_pdma_far_model (.mclk(mclk), .mem_req(mem_req), .per_req(per_req),
      .mem_rsp(mem_rsp), .per_rdata(per_rdata));
   task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", n, exp, got);
      end
   endtask : chk
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge mclk) reg_req <= {1'b1, 1'b0, a, d};
      @(posedge mclk) reg_req <= '0;
   endtask : wr
   task automatic rc(input logic [11:0] a, input logic [31:0] exp);
      @(posedge mclk) reg_req <= {1'b0, 1'b1, a, 32'h00000000};
      @(posedge mclk) reg_req <= '0;
      #1 chk($sformatf("reg %h", a), reg_rdata, exp);
   endtask : rc
   // Bounded wait: 0 periph write, 1 memory write, 2 irq, 3 ack
   task automatic wait_ev(input int k);
      logic ev;
      for (int i = 0; i < 60; i++)
      begin
         @(negedge mclk);
         ev = k == 0 ? per_req.wr : k == 1 ? mem_req.req & mem_req.write : k == 2 ? irq[0] : |hs_ack;
         if (ev === 1'b1)
            break;
      end
      chk($sformatf("event %0d", k), {31'h0, ev}, 32'h00000001);
   endtask : wait_ev
   task automatic t_reset();
      rc(12'h008, 32'h00000000);
      rc(12'h02c, 32'h00000003);
      rc(12'h028, 32'h00000000);
      rc(12'h900, 32'h00000000);
      $display("test reset done");
   endtask : t_reset
   // Two words memory to peripheral on channel 0
   task automatic t_word();
      wr(12'h004, 32'h00000001);
      wr(12'h018, 32'h00000002);
      wr(12'h000, 32'h00000100);
      wr(12'h008, 32'h00000002);
      wr(12'h014, 32'h00000001);
      rc(12'h01c, 32'h00000001);
      @(posedge mclk) hs_req <= 4'h1;
      wait_ev(0);
      chk("pdata", per_req.wdata, 32'hfffffeff);
      chk("paddr", {24'h0, per_req.addr}, 32'h00000001);
      wait_ev(0);
      chk("pdata", per_req.wdata, 32'hfffffefb);
      @(posedge mclk) hs_req <= 4'h0;
      rc(12'h000, 32'h00000108);
      rc(12'h008, 32'h00000000);
      $display("test word done");
   endtask : t_word
   // Reload start on ch0 racing a byte read on ch1
   task automatic t_prio();
      wr(12'h00c, 32'h00000200);
      wr(12'h010, 32'h00000001);
      rc(12'h000, 32'h00000200);
      rc(12'h010, 32'h00000000);
      wr(12'h044, 32'h00000002);
      wr(12'h040, 32'h00000300);
      wr(12'h048, 32'h00000001);
      wr(12'h054, 32'h00000001);
      @(posedge mclk) hs_req <= 4'h3;
      wait_ev(3);
      chk("ack", {28'h0, hs_ack}, 32'h00000001);
      wait_ev(1);
      @(posedge mclk) hs_req <= 4'h0;
      chk("mdata", mem_req.wdata, 32'h0000000d);
      chk("msize", {30'h0, mem_req.size}, 32'h00000000);
      chk("maddr", mem_req.addr, 32'h00000300);
      $display("test prio done");
   endtask : t_prio
   // Failing address stops channel 0, error clear restarts it
   task automatic t_error();
      wr(12'h00c, 32'h00000f00);
      wr(12'h010, 32'h00000001);
      wr(12'h020, 32'h00000004);
      @(posedge mclk) hs_req <= 4'h1;
      wait_ev(2);
      rc(12'h02c, 32'h00000005);
      rc(12'h008, 32'h00000001);
      wr(12'h000, 32'h00000400);
      wr(12'h014, 32'h00000100);
      wait_ev(0);
      chk("pdata", per_req.wdata, 32'hfffffbff);
      @(posedge mclk) hs_req <= 4'h0;
      wr(12'h024, 32'h00000004);
      rc(12'h028, 32'h00000000);
      $display("test error done");
   endtask : t_error
   // Monitor 0 on a channel 1 write, reload on done, channel 1 mask
   task automatic t_monitor();
      wr(12'h800, 32'h00010001);
      wr(12'h048, 32'h00000001);
      wr(12'h04c, 32'h00000340);
      wr(12'h050, 32'h00000001);
      @(posedge mclk) hs_req <= 4'h2;
      wait_ev(1);
      repeat (2) @(posedge mclk) hs_req <= 4'h0;
      rc(12'h810, 32'h00000001);
      rc(12'h814, 32'h00000002);
      rc(12'h818, 32'h00000002);
      rc(12'h804, 32'h00000000);
      rc(12'h040, 32'h00000340);
      rc(12'h048, 32'h00000001);
      rc(12'h050, 32'h00000000);
      wr(12'h800, 32'h00010011);
      rc(12'h800, 32'h00010001);
      rc(12'h810, 32'h00000000);
      rc(12'h818, 32'h00000000);
      wr(12'h060, 32'h00000001);
      #1 chk("irq1", {31'h0, irq[1]}, 32'h00000001);
      wr(12'h064, 32'h00000001);
      #1 chk("irq1", {31'h0, irq[1]}, 32'h00000000);
      $display("test monitor done");
   endtask : t_monitor
   task automatic final_report();
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : final_report
   // Main sequence
   initial
   begin
      repeat (20) @(posedge mclk);
      reset <= 1'b0;
      t_reset();
      t_word();
      t_prio();
      t_error();
      t_monitor();
      final_report();
   end
   // Watchdog
   initial
   begin
      #40000;
      bad_count++;
      final_report();
   end
endmodule : tb
